// *** hw/tccr_pkg.sv ***
// package for the timer capture/compare register block
// assumes a 32-bit axi4-lite master and one 10 MHz clock
package tccr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] TCCR_OFF_CCA = 8'h00;
  localparam logic [7:0] TCCR_OFF_CCB = 8'h04;
  localparam logic [7:0] TCCR_OFF_CTRL = 8'h08;
  localparam logic [7:0] TCCR_OFF_MODE = 8'h0c;
  localparam logic [7:0] TCCR_OFF_CNT = 8'h10;
  localparam logic [7:0] TCCR_OFF_STAT = 8'h14;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  // control: written as bit0 a is capture, bit1 a trigger is input b edge; a read returns these two bits swapped
  localparam int TCCR_CTRL_A_CAPTURE = 0;
  localparam int TCCR_CTRL_A_SEL_B = 1;
  // mode: bits 1:0 count mode (00 stops), bit2 input b edge (0 rise, 1 fall),
  // bit3 input a valid edge (0 rise, 1 fall)
  localparam int TCCR_MODE_LOW = 0;
  localparam int TCCR_MODE_HIGH = 1;
  localparam int TCCR_MODE_B_FALL = 2;
  localparam int TCCR_MODE_A_FALL = 3;
  localparam logic [15:0] TCCR_CC_RESET = 16'h0000;
  localparam logic [3:0] TCCR_CTRL_RESET = 4'h0;
  localparam logic [3:0] TCCR_MODE_RESET = 4'h0;
  localparam int TCCR_SYNC_STAGES = 3;

  localparam logic [1:0] TCCR_RESP_OKAY = 2'b00;
  localparam logic [1:0] TCCR_RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic a_capture;
    logic a_sel_b;
  } tccr_ctrl_type;

  typedef struct packed {
    logic timer_input_a;
    logic timer_input_b;
  } tccr_pins_type;

  typedef enum logic [1:0] {
    TCCR_W_IDLE = 2'b01,
    TCCR_W_RESP = 2'b10
  } tccr_wstate_type;

endpackage

// *** hw/tccr_top.sv ***
// capture/compare pair on a free-running 16-bit counter, axi4-lite slave
// assumes trigger pins are asynchronous; software keeps write timing rules
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

// Contract
// - two 16-bit registers, each capture or compare, chosen by control register; here only register a does this, b just holds what is written
// - both registers accessed only as whole 16-bit quantities
// - reset clears both registers to 0000
// - compare use: match of register a and counter raises interrupt request
// - compare value held until software writes a new one
// - compare use ignores capture triggers, contents unchanged
// - capture use loads counter into register a on a trigger
// - trigger is input a opposite edge or input b valid edge
// - reduced variant allows only input a inverted edge as trigger
module tccr_top #(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trigger pins
  input wire tccr_pkg::tccr_pins_type trig_pins,
  // counter and match pulse
  output logic [15:0] sixteen_bit_counter,
  output logic match_interrupt_a
);
  import tccr_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] capture_compare_a_ff;
  logic [15:0] capture_compare_b_ff;
  logic [15:0] counter_ff;
  tccr_ctrl_type capture_compare_control_ff;
  logic [3:0] prescaler_mode_reg_ff;
  logic match_ff;
  logic capt_seen_ff;
  logic odd_write_ff;
  logic [TCCR_SYNC_STAGES-1:0] sync_a_ff;
  logic [TCCR_SYNC_STAGES-1:0] sync_b_ff;
  logic lvl_a_ff;
  logic lvl_b_ff;
  tccr_wstate_type wstate_ff;
  logic aw_have_ff;
  logic w_have_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  logic running;
  logic wr_fire;
  logic edge_a_rise;
  logic edge_a_fall;
  logic edge_b_rise;
  logic edge_b_fall;
  logic trig_a_opp;
  logic trig_b_valid;
  logic capture_now;
  logic write_cca;
  logic write_ccb;
  logic [15:0] nxt_capture_compare_a;

  // both low bytes enabled means a whole 16-bit access
  function automatic logic whole_half(input logic [3:0] strb);
    return strb[1:0] == 2'b11;
  endfunction

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // shared by both channels so write and read agree on what is mapped
  function automatic logic addr_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == TCCR_OFF_CCA) begin
      hit = 1'b1;
    end else if (addr == TCCR_OFF_CCB) begin
      hit = 1'b1;
    end else if (addr == TCCR_OFF_CTRL) begin
      hit = 1'b1;
    end else if (addr == TCCR_OFF_MODE) begin
      hit = 1'b1;
    end else if (addr == TCCR_OFF_CNT) begin
      hit = 1'b1;
    end else if (addr == TCCR_OFF_STAT) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  assign running = prescaler_mode_reg_ff[TCCR_MODE_HIGH] | prescaler_mode_reg_ff[TCCR_MODE_LOW];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // level changes only once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a_ff <= '0;
      sync_b_ff <= '0;
      lvl_a_ff <= 1'b0;
      lvl_b_ff <= 1'b0;
    end else begin
      sync_a_ff <= {sync_a_ff[TCCR_SYNC_STAGES-2:0], trig_pins.timer_input_a};
      sync_b_ff <= {sync_b_ff[TCCR_SYNC_STAGES-2:0], trig_pins.timer_input_b};
      if (sync_a_ff[2] == sync_a_ff[1]) begin
        lvl_a_ff <= sync_a_ff[2];
      end
      if (sync_b_ff[2] == sync_b_ff[1]) begin
        lvl_b_ff <= sync_b_ff[2];
      end
    end
  end

  assign edge_a_rise = (sync_a_ff[2] == sync_a_ff[1]) && sync_a_ff[2] && !lvl_a_ff;
  assign edge_a_fall = (sync_a_ff[2] == sync_a_ff[1]) && !sync_a_ff[2] && lvl_a_ff;
  assign edge_b_rise = (sync_b_ff[2] == sync_b_ff[1]) && sync_b_ff[2] && !lvl_b_ff;
  assign edge_b_fall = (sync_b_ff[2] == sync_b_ff[1]) && !sync_b_ff[2] && lvl_b_ff;

  // ----------------------------------------------------------------
  // trigger selection
  // ----------------------------------------------------------------
  // opposite edge of input a
  assign trig_a_opp = prescaler_mode_reg_ff[TCCR_MODE_A_FALL] ? edge_a_rise : edge_a_fall;
  assign trig_b_valid = prescaler_mode_reg_ff[TCCR_MODE_B_FALL] ? edge_b_fall : edge_b_rise;
  assign capture_now = capture_compare_control_ff.a_capture &&
    ((capture_compare_control_ff.a_sel_b && !REDUCED_VARIANT) ? trig_b_valid : trig_a_opp);

  // ----------------------------------------------------------------
  // free-running counter
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_ff <= TCCR_CC_RESET;
    end else if (running) begin
      counter_ff <= counter_ff + 16'h0001;
    end else begin
      counter_ff <= TCCR_CC_RESET;
    end
  end
  assign sixteen_bit_counter = counter_ff;

  // ----------------------------------------------------------------
  // register a and b
  // ----------------------------------------------------------------
  assign wr_fire = (wstate_ff == TCCR_W_IDLE) && aw_have_ff && w_have_ff;
  assign write_cca = wr_fire && (awaddr_ff == TCCR_OFF_CCA) && whole_half(wstrb_ff);
  assign write_ccb = wr_fire && (awaddr_ff == TCCR_OFF_CCB) && whole_half(wstrb_ff);

  // capture beats a write in the same cycle
  always_comb begin
    nxt_capture_compare_a = capture_compare_a_ff;
    if (capture_now) begin
      nxt_capture_compare_a = counter_ff;
    end else if (write_cca) begin
      nxt_capture_compare_a = wdata_ff[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_compare_a_ff <= TCCR_CC_RESET;
      capture_compare_b_ff <= TCCR_CC_RESET;
    end else begin
      capture_compare_a_ff <= nxt_capture_compare_a;
      if (write_ccb) begin
        capture_compare_b_ff <= wdata_ff[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // control, mode and status
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_compare_control_ff <= tccr_ctrl_type'(TCCR_CTRL_RESET[1:0]);
      prescaler_mode_reg_ff <= TCCR_MODE_RESET;
    end else if (wr_fire && wstrb_ff[0]) begin
      if (awaddr_ff == TCCR_OFF_CTRL) begin
        capture_compare_control_ff.a_capture <= wdata_ff[TCCR_CTRL_A_CAPTURE];
        capture_compare_control_ff.a_sel_b <= wdata_ff[TCCR_CTRL_A_SEL_B];
      end else if (awaddr_ff == TCCR_OFF_MODE) begin
        prescaler_mode_reg_ff <= wdata_ff[3:0];
      end
    end
  end

  // status: bit0 capture seen (write 1 clears, set wins), bit1 write to a while running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capt_seen_ff <= 1'b0;
      odd_write_ff <= 1'b0;
    end else begin
      if (capture_now) begin
        capt_seen_ff <= 1'b1;
      end else if (wr_fire && awaddr_ff == TCCR_OFF_STAT && wstrb_ff[0] && wdata_ff[0]) begin
        capt_seen_ff <= 1'b0;
      end
      // flag a write to a while running
      if (write_cca && running) begin
        odd_write_ff <= 1'b1;
      end else if (wr_fire && awaddr_ff == TCCR_OFF_STAT && wstrb_ff[0] && wdata_ff[1]) begin
        odd_write_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // compare match
  // ----------------------------------------------------------------
  // compare every count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= running && !capture_compare_control_ff.a_capture &&
        (counter_ff == capture_compare_a_ff);
    end
  end
  assign match_interrupt_a = match_ff;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = (wstate_ff == TCCR_W_IDLE) && !aw_have_ff;
  assign s_axi_wready = (wstate_ff == TCCR_W_IDLE) && !w_have_ff;
  assign s_axi_bvalid = (wstate_ff == TCCR_W_RESP);
  assign s_axi_bresp = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_ff <= TCCR_W_IDLE;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bresp_ff <= TCCR_RESP_OKAY;
    end else begin
      case (wstate_ff)
        TCCR_W_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_have_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_have_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
          end
          if (wr_fire) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            wstate_ff <= TCCR_W_RESP;
            bresp_ff <= addr_mapped(awaddr_ff) ? TCCR_RESP_OKAY : TCCR_RESP_SLVERR;
          end
        end
        TCCR_W_RESP: begin
          if (s_axi_bready) begin
            wstate_ff <= TCCR_W_IDLE;
          end
        end
        default: begin
          wstate_ff <= TCCR_W_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= TCCR_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= addr_mapped(s_axi_araddr) ? TCCR_RESP_OKAY : TCCR_RESP_SLVERR;
      // whole 16-bit reads, upper half zero
      if (s_axi_araddr == TCCR_OFF_CCA) begin
        rdata_ff <= {16'h0000, capture_compare_a_ff};
      end else if (s_axi_araddr == TCCR_OFF_CCB) begin
        rdata_ff <= {16'h0000, capture_compare_b_ff};
      end else if (s_axi_araddr == TCCR_OFF_CTRL) begin
        rdata_ff <= {30'h0000_0000, capture_compare_control_ff};
      end else if (s_axi_araddr == TCCR_OFF_MODE) begin
        rdata_ff <= {28'h000_0000, prescaler_mode_reg_ff};
      end else if (s_axi_araddr == TCCR_OFF_CNT) begin
        rdata_ff <= {16'h0000, counter_ff};
      end else if (s_axi_araddr == TCCR_OFF_STAT) begin
        rdata_ff <= {30'h0000_0000, odd_write_ff, capt_seen_ff};
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

// *** tb/tccr_assertions.sv ***
// checker for the capture/compare block: bus answers and match pulse
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
module tccr_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // read and write answers
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // counter and match
  input wire logic [15:0] sixteen_bit_counter,
  input wire logic match_interrupt_a
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------
  // counter and match
  // ---------------------------------------------
  reset_clear_a:
  assert property ($rose(aresetn) |-> sixteen_bit_counter == 16'h0000 && !match_interrupt_a)
    else $error("counter or match not clear after reset");
  count_step_a:
  assert property (sixteen_bit_counter != 16'h0000 |-> sixteen_bit_counter == $past(sixteen_bit_counter) + 16'h0001)
    else $error("counter skipped a value");
  pulse_one_a:
  assert property (match_interrupt_a |=> !match_interrupt_a)
    else $error("match pulse longer than one cycle");
  // ---------------------------------------------
  // bus answers
  // ---------------------------------------------
  read_answer_a:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  read_hold_a:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  read_block_a:
  assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  upper_zero_a:
  assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  write_hold_a:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule

bind tccr_top tccr_assertions tccr_assertions_i (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .sixteen_bit_counter, .match_interrupt_a);

// *** tb/tccr_pin_model.sv ***
// trigger pin source standing outside the capture/compare block
// assumes pins are sampled asynchronously by the block
`timescale 1ns/1ps
module tccr_pin_model
  import tccr_pkg::*;
(
  // clock
  input wire logic aclk,
  // pins
  output tccr_pkg::tccr_pins_type trig_pins
);
  initial trig_pins = '0;
  // drive one trigger pin
  // held six cycles so the synchroniser surely sees it
  task automatic set_pin(input logic sel_b, input logic lvl);
    @(posedge aclk);
    if (sel_b) begin
      trig_pins.timer_input_b <= lvl;
    end else begin
      trig_pins.timer_input_a <= lvl;
    end
    repeat (6) @(posedge aclk);
  endtask
endmodule

// *** tb/test_timer16_capture_compare_regs.sv ***
// self-checking bench for the capture/compare register block
// assumes the pin model and the bound checker sit beside the design
`timescale 1ns/1ps
module test_timer16_capture_compare_regs;
  import tccr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic match_interrupt_a;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rd;
  logic [15:0] sixteen_bit_counter, c0;
  tccr_pins_type trig_pins;
  int mismatches = 0;
  int n_tests = 0;

  always #50 aclk = ~aclk;
  tccr_top tccr_top_i (.*);
  tccr_pin_model tccr_pin_model_i (.aclk, .trig_pins);

  // ---------------------------------------------
  // report and bus tasks
  // ---------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  // handshakes judged at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) break;
    end
    s_axi_bready <= 1'b0;
    chk("write answer", 1, i < 20);
    if (i == 20) complete_run();
    chk("write response", {30'h0, (a > 8'h14) ? TCCR_RESP_SLVERR : TCCR_RESP_OKAY}, rr);
  endtask
  task automatic rdr(input logic [7:0] a);
    int i;
    logic ah, dh;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      dh = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (dh) break;
    end
    s_axi_rready <= 1'b0;
    chk("read answer", 1, i < 20);
    if (i == 20) complete_run();
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset();
    for (int k = 0; k < 6; k++) begin
      rdr(8'(k * 4));
      chk("reset value", 32'h0, rd);
    end
    rdr(8'h18);
    chk("unmapped resp", {30'h0, TCCR_RESP_SLVERR}, rr);
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask
  task automatic t_access();
    wr(TCCR_OFF_CCA, 32'hffff_1234, 4'hf);
    rdr(TCCR_OFF_CCA);
    chk("cca word", 32'h1234, rd);
    wr(TCCR_OFF_CCB, 32'h0000_abcd, 4'h1);
    rdr(TCCR_OFF_CCB);
    chk("ccb byte write", 32'h0, rd);
    wr(TCCR_OFF_CCB, 32'h0000_abcd, 4'h3);
    rdr(TCCR_OFF_CCB);
    chk("ccb word", 32'habcd, rd);
    wr(8'h20, 32'h1, 4'hf);
    $display("test access done");
  endtask
  task automatic t_compare();
    int i;
    wr(TCCR_OFF_CCA, 32'h20, 4'hf);
    wr(TCCR_OFF_MODE, 32'h1, 4'hf);
    for (i = 0; i < 200 && match_interrupt_a !== 1'b1; i++) @(negedge aclk);
    chk("match seen", 1, i < 200);
    if (i == 200) complete_run();
    chk("count at match", 32'h21, {16'h0, sixteen_bit_counter});
    tccr_pin_model_i.set_pin(1'b0, 1'b1);
    tccr_pin_model_i.set_pin(1'b0, 1'b0);
    rdr(TCCR_OFF_CCA);
    chk("compare value held", 32'h20, rd);
    $display("test compare done");
  endtask
  task automatic t_capture();
    wr(TCCR_OFF_CTRL, 32'h1, 4'hf);
    tccr_pin_model_i.set_pin(1'b0, 1'b1);
    rdr(TCCR_OFF_CCA);
    chk("valid edge ignored", 32'h20, rd);
    @(negedge aclk);
    c0 = sixteen_bit_counter;
    tccr_pin_model_i.set_pin(1'b0, 1'b0);
    rdr(TCCR_OFF_CCA);
    chk("capture on a", 1, (rd[15:0] - c0) inside {[16'd2:16'd12]});
    wr(TCCR_OFF_CTRL, 32'h3, 4'hf);
    @(negedge aclk);
    c0 = sixteen_bit_counter;
    tccr_pin_model_i.set_pin(1'b1, 1'b1);
    rdr(TCCR_OFF_CCA);
    chk("capture on b", 1, (rd[15:0] - c0) inside {[16'd2:16'd12]});
    rdr(TCCR_OFF_STAT);
    chk("capture seen", 32'h1, rd);
    wr(TCCR_OFF_STAT, 32'h1, 4'hf);
    rdr(TCCR_OFF_STAT);
    chk("capture seen clear", 32'h0, rd);
    wr(TCCR_OFF_MODE, 32'h0, 4'hf);
    $display("test capture done");
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_access();
    t_compare();
    t_capture();
    complete_run();
  end
endmodule
